//--- core/ism_slave.sv
// slave-mode bus handler: address match, event request, clock hold
//
// Added by the designer: the register addresses and the one-cycle strobe port to the registers.
`timescale 1ns/1ps
module ism_slave (
    input  wire logic       clk,
    input  wire logic       reset_n,
    ism_link_if.dev         link,
    input  wire logic [1:0] reg_sel,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            bus_event_irq
);
    typedef struct packed {
        logic [7:0] own;       // own_address_reg
        logic       controller_role;       // controller_role
        logic       transmit_direction;       // transmit_direction
        logic       pin;       // pending release flag
        logic [2:0] bc;        // bit_count_field
        logic       al;        // lost_arbitration_flag
        logic       addressed_as_slave;       // addressed_as_slave
        logic       ad0;       // zero_broadcast_flag
        logic       last_bit_sampled;       // last_bit_sampled
        logic [7:0] sh;        // shared tx/rx shifter
        logic [3:0] cnt;       // clock rises in this word
        logic       first;     // first word after start
        logic       sel;       // addressed since start
        logic       hit;       // address byte accepted
        logic       sda_drv;   // pulling data low for a bit
        logic       ack_drv;   // pulling data low for ack
        logic       hold;      // holding clock low
        logic       rel;       // release timer running
        logic [7:0] tmr;
        logic       irq;
        logic [7:0] rdata;
    } ism_slave_st_t;

    ism_slave_st_t s_q;
    ism_slave_st_t s_d;

    logic       scl_lvl;
    logic       scl_rise;
    logic       scl_fall;
    logic       sda_lvl;
    logic       sda_rise;
    logic       sda_fall;
    logic [3:0] wlen;
    logic       tx;
    logic       bus_start;
    logic       bus_stop;
    logic       addr_hit;
    logic       start_byte;

    ism_sync u_scl (
        .clk     (clk),
        .reset_n (reset_n),
        .din     (link.scl),
        .lvl     (scl_lvl),
        .rise    (scl_rise),
        .fall    (scl_fall)
    );

    ism_sync u_sda (
        .clk     (clk),
        .reset_n (reset_n),
        .din     (link.sda),
        .lvl     (sda_lvl),
        .rise    (sda_rise),
        .fall    (sda_fall)
    );

    // word length, zero count meaning a full byte
    assign wlen      = (s_q.bc == 3'h0) ? 4'h8 : {1'b0, s_q.bc};
    assign tx        = s_q.transmit_direction & (s_q.controller_role | s_q.sel);
    assign bus_start = sda_fall & scl_lvl;
    assign bus_stop  = sda_rise & scl_lvl;
    // zero own address with the start byte is a match of its own
    assign start_byte = (s_q.own == 8'h00) & (s_q.sh == ism_pkg::START_BYTE);
    assign addr_hit   = (s_q.sh[7:1] == s_q.own[7:1])
                      | (s_q.sh == ism_pkg::GEN_CALL)
                      | start_byte;

    // next state: register port first, bus events after so they win
    always_comb begin
        s_d     = s_q;
        s_d.irq = 1'b0;

        // release timer: clock stays low a full low time after release
        if (s_q.rel) begin
            s_d.tmr = s_q.tmr + 8'h01;
            if (s_q.tmr == ism_pkg::LOW_HOLD_CYC - 8'h01) begin
                s_d.hold = 1'b0;
                s_d.rel  = 1'b0;
            end
        end

        // register writes
        if (reg_wr) begin
            unique case (reg_sel)
                ism_pkg::REG_CTRL: begin
                    s_d.controller_role = reg_wdata[ism_pkg::CTRL_MST];
                    s_d.transmit_direction = reg_wdata[ism_pkg::CTRL_TRX];
                    s_d.bc  = reg_wdata[ism_pkg::CTRL_BC +: 3];
                    s_d.al  = 1'b0;
                    if (reg_wdata[ism_pkg::CTRL_PIN] && !s_q.pin) begin
                        s_d.pin = 1'b1;
                        s_d.rel = 1'b1;
                        s_d.tmr = 8'h00;
                    end
                end
                ism_pkg::REG_DATA: begin
                    s_d.sh      = reg_wdata;
                    // first bit goes out at once, clock is still low
                    s_d.sda_drv = tx & ~reg_wdata[7];
                end
                ism_pkg::REG_ADDR: begin
                    s_d.own = reg_wdata;
                end
                default: begin
                end
            endcase
        end

        // any data buffer access clears flags and frees the clock
        if ((reg_wr || reg_rd) && reg_sel == ism_pkg::REG_DATA) begin
            s_d.al  = 1'b0;
            s_d.addressed_as_slave = 1'b0;
            if (!s_q.pin) begin
                s_d.pin = 1'b1;
                s_d.rel = 1'b1;
                s_d.tmr = 8'h00;
            end
        end

        // start condition: new address phase
        if (bus_start) begin
            s_d.cnt     = 4'h0;
            s_d.first   = 1'b1;
            s_d.sel     = 1'b0;
            s_d.hit     = 1'b0;
            s_d.ad0     = 1'b0;
            s_d.ack_drv = 1'b0;
            // first bit waits for the first fall, never while clock high
            s_d.sda_drv = 1'b0;
        end

        // stop condition: bus goes idle, nothing held
        if (bus_stop) begin
            s_d.cnt     = 4'h0;
            s_d.first   = 1'b0;
            s_d.sel     = 1'b0;
            s_d.ad0     = 1'b0;
            s_d.ack_drv = 1'b0;
            s_d.sda_drv = 1'b0;
            s_d.hold    = 1'b0;
            s_d.rel     = 1'b0;
            s_d.pin     = 1'b1;
        end

        // clock rise: sample data, shift, check arbitration
        if (scl_rise && s_q.cnt <= wlen) begin
            s_d.last_bit_sampled = sda_lvl;
            if (s_q.cnt < wlen) begin
                s_d.sh = {s_q.sh[6:0], sda_lvl};
                // sending a one but the line is low: another master won
                if (s_q.controller_role && s_q.transmit_direction && !s_q.sda_drv && !sda_lvl) begin
                    s_d.al      = 1'b1;
                    s_d.controller_role     = 1'b0;
                    s_d.transmit_direction     = 1'b0;
                end
            end
            s_d.cnt = s_q.cnt + 4'h1;
        end

        // clock fall: present next bit, ack, or close the word
        if (scl_fall) begin
            if (s_q.cnt < wlen) begin
                s_d.sda_drv = tx & ~s_q.sh[7];
            end else if (s_q.cnt == wlen) begin
                s_d.sda_drv = 1'b0;
                s_d.hit     = s_q.first & ~s_q.controller_role & addr_hit;
                s_d.ack_drv = s_q.first ? (~s_q.controller_role & addr_hit)
                                        : (s_q.sel & ~s_q.transmit_direction);
            end else if (s_q.cnt == 4'(wlen + 4'h1)) begin
                s_d.ack_drv = 1'b0;
                s_d.cnt     = 4'h0;
                s_d.first   = 1'b0;
                if (s_q.first && s_q.hit) begin
                    // addressed: own address, general call or start byte
                    s_d.sel = 1'b1;
                    s_d.addressed_as_slave = 1'b1;
                    s_d.ad0 = (s_q.sh == ism_pkg::GEN_CALL);
                    s_d.transmit_direction = s_q.sh[0] | start_byte;
                    s_d.irq = 1'b1;
                    s_d.pin = 1'b0;
                    s_d.hold = 1'b1;
                    s_d.rel = 1'b0;
                end else if (s_q.sel || (s_q.controller_role && !s_q.al)) begin
                    s_d.irq  = 1'b1;
                    s_d.pin  = 1'b0;
                    s_d.hold = 1'b1;
                    s_d.rel  = 1'b0;
                end else if (s_q.al) begin
                    // lost and not addressed: report, clock not held
                    s_d.irq = 1'b1;
                end
            end
        end

        // read data is captured the cycle after the strobe
        unique case (reg_sel)
            ism_pkg::REG_CTRL: s_d.rdata = {s_q.controller_role, s_q.transmit_direction, 1'b0, s_q.pin,
                                            1'b0, s_q.bc};
            ism_pkg::REG_DATA: s_d.rdata = s_q.sh;
            ism_pkg::REG_STAT: s_d.rdata = {s_q.controller_role, s_q.transmit_direction, 2'h0, s_q.al,
                                            s_q.addressed_as_slave, s_q.ad0, s_q.last_bit_sampled};
            default:           s_d.rdata = s_q.own;
        endcase
    end

    // all handler state except the two line synchronisers in one register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q       <= '0;
            s_q.own   <= ism_pkg::ADDR_RST;
            s_q.pin   <= ism_pkg::CTRL_RST[ism_pkg::CTRL_PIN];
        end else begin
            s_q <= s_d;
        end
    end

    // open-drain drivers; release of the clock is delayed by the timer
    assign link.dev_scl_oe = s_q.hold;
    assign link.dev_sda_oe = s_q.sda_drv | s_q.ack_drv;
    assign reg_rdata       = s_q.rdata;
    assign bus_event_irq   = s_q.irq;
endmodule

//--- core/ism_pkg.sv
// shared constants for the slave-mode bus handler and its far-end master
package ism_pkg;
    // system clock and link timing
    localparam int         CLK_NS       = 40;
    localparam int         LOW_HOLD_NS  = 4700;
    localparam logic [7:0] LOW_HOLD_CYC = 8'((LOW_HOLD_NS + CLK_NS - 1) / CLK_NS);
    localparam int         SCL_HALF_NS  = 800;
    localparam logic [7:0] SCL_HALF_CYC = 8'(SCL_HALF_NS / CLK_NS);

    // device register indices on its own port
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_DATA = 2'h1;
    localparam logic [1:0] REG_STAT = 2'h2;
    localparam logic [1:0] REG_ADDR = 2'h3;

    // control_b_reg fields
    localparam int CTRL_MST = 7;
    localparam int CTRL_TRX = 6;
    localparam int CTRL_PIN = 4;
    localparam int CTRL_BC  = 0;
    localparam logic [7:0] CTRL_RST = 8'h10;
    localparam logic [7:0] ADDR_RST = 8'h00;

    // status_b_reg fields
    localparam int STAT_MST = 7;
    localparam int STAT_TRX = 6;
    localparam int STAT_AL  = 3;
    localparam int STAT_AAS = 2;
    localparam int STAT_AD0 = 1;
    localparam int STAT_LRB = 0;

    // special address bytes
    localparam logic [7:0] GEN_CALL   = 8'h00;
    localparam logic [7:0] START_BYTE = 8'h01;

    // far-end master apb map
    localparam logic [7:0] APB_CMD  = 8'h00;
    localparam logic [7:0] APB_STAT = 8'h04;
    localparam logic [7:0] APB_MASK = 8'h08;
    localparam logic [7:0] APB_RXD  = 8'h0C;
    localparam int CMD_GO    = 16;
    localparam int EV_DONE   = 0;
    localparam int EV_NACK   = 1;
    localparam int STAT_BUSY = 2;
endpackage

//--- core/ism_link_if.sv
// open-drain two-wire link joining the slave handler and the far master
`timescale 1ns/1ps
interface ism_link_if;
    logic dev_scl_oe;
    logic dev_sda_oe;
    logic host_scl_oe;
    logic host_sda_oe;
    logic scl;
    logic sda;

    // wired-and: any enabled driver pulls the line low
    assign scl = ~(dev_scl_oe | host_scl_oe);
    assign sda = ~(dev_sda_oe | host_sda_oe);

    modport dev  (input scl, input sda, output dev_scl_oe, output dev_sda_oe);
    modport host (input scl, input sda, output host_scl_oe,
                  output host_sda_oe);
endinterface

//--- core/ism_sync.sv
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module ism_sync (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic din,
    output logic      lvl,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic meta;
        logic stab;
        logic prev;
    } ism_sync_st_t;

    ism_sync_st_t s_q;
    ism_sync_st_t s_d;

    // only the second and third stages are looked at by logic
    always_comb begin
        s_d      = s_q;
        s_d.meta = din;
        s_d.stab = s_q.meta;
        s_d.prev = s_q.stab;
    end

    // idle bus lines are high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= 3'h7;
        end else begin
            s_q <= s_d;
        end
    end

    assign lvl  = s_q.stab;
    assign rise = s_q.stab & ~s_q.prev;
    assign fall = ~s_q.stab & s_q.prev;
endmodule

//--- core/ism_master.sv
// far-end bus master: apb command port, one address and one data word
`timescale 1ns/1ps
module ism_master (
    input  wire logic        clk,
    input  wire logic        reset_n,
    ism_link_if.host         link,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_LOW   = 5'h04,
        ST_HIGH  = 5'h08,
        ST_STOP  = 5'h10
    } ism_mst_state_t;

    typedef struct packed {
        ism_mst_state_t st;
        logic [7:0]     tmr;
        logic [3:0]     bitn;
        logic           byten;
        logic           rw;
        logic [7:0]     sh;
        logic [7:0]     wdat;
        logic [7:0]     rxd;
        logic           nack;
        logic           scl_oe;
        logic           sda_oe;
        logic [1:0]     stat;
        logic [1:0]     mask;
        logic [31:0]    prdata;
    } ism_mst_st_t;

    ism_mst_st_t s_q;
    ism_mst_st_t s_d;

    logic       scl_lvl;
    logic       sda_lvl;
    logic       acc;
    logic       mapped;
    logic [1:0] ev;
    logic [7:0] half;

    ism_sync u_scl (
        .clk     (clk),
        .reset_n (reset_n),
        .din     (link.scl),
        .lvl     (scl_lvl),
        .rise    (),
        .fall    ()
    );

    ism_sync u_sda (
        .clk     (clk),
        .reset_n (reset_n),
        .din     (link.sda),
        .lvl     (sda_lvl),
        .rise    (),
        .fall    ()
    );

    assign half   = ism_pkg::SCL_HALF_CYC;
    assign acc    = psel & penable;
    assign mapped = (paddr == ism_pkg::APB_CMD) | (paddr == ism_pkg::APB_STAT)
                  | (paddr == ism_pkg::APB_MASK) | (paddr == ism_pkg::APB_RXD);

    always_comb begin
        s_d = s_q;
        ev  = 2'h0;

        // apb: read data latched in setup, effects in access phase
        if (psel && !penable) begin
            unique case (paddr)
                ism_pkg::APB_STAT: s_d.prdata = {29'h0,
                                     s_q.st != ST_IDLE, s_q.stat};
                ism_pkg::APB_MASK: s_d.prdata = {30'h0, s_q.mask};
                ism_pkg::APB_RXD:  s_d.prdata = {24'h0, s_q.rxd};
                default:           s_d.prdata = 32'h0;
            endcase
        end
        if (acc && pwrite && paddr == ism_pkg::APB_MASK) begin
            s_d.mask = pwdata[1:0];
        end
        if (acc && pwrite && paddr == ism_pkg::APB_CMD
            && pwdata[ism_pkg::CMD_GO] && s_q.st == ST_IDLE) begin
            s_d.sh     = pwdata[7:0];
            s_d.rw     = pwdata[0];
            s_d.wdat   = pwdata[15:8];
            s_d.nack   = 1'b0;
            s_d.tmr    = 8'h00;
            s_d.sda_oe = 1'b1; // start: data falls while clock high
            s_d.st     = ST_START;
        end

        // bit engine; clock high phase waits for any stretching slave
        unique case (s_q.st)
            ST_IDLE: begin
            end
            ST_START: begin
                s_d.tmr = s_q.tmr + 8'h01;
                if (s_q.tmr == half - 8'h01) begin
                    s_d.scl_oe = 1'b1;
                    s_d.tmr    = 8'h00;
                    s_d.bitn   = 4'h0;
                    s_d.byten  = 1'b0;
                    s_d.st     = ST_LOW;
                end
            end
            ST_LOW: begin
                s_d.tmr = s_q.tmr + 8'h01;
                // data changes mid-low, well away from clock edges
                if (s_q.tmr == {1'b0, half[7:1]}) begin
                    s_d.sda_oe = (s_q.bitn < 4'h8) & ~s_q.sh[7]
                               & (~s_q.byten | ~s_q.rw);
                end
                if (s_q.tmr == half - 8'h01) begin
                    s_d.scl_oe = 1'b0;
                    s_d.tmr    = 8'h00;
                    s_d.st     = ST_HIGH;
                end
            end
            ST_HIGH: begin
                s_d.tmr = scl_lvl ? s_q.tmr + 8'h01 : 8'h00;
                if (scl_lvl && s_q.tmr == half - 8'h01) begin
                    s_d.scl_oe = 1'b1;
                    s_d.tmr    = 8'h00;
                    s_d.st     = ST_LOW;
                    if (s_q.bitn < 4'h8) begin
                        s_d.sh   = {s_q.sh[6:0], sda_lvl};
                        s_d.bitn = s_q.bitn + 4'h1;
                    end else begin
                        if (s_q.byten) begin
                            s_d.rxd = s_q.sh;
                        end else begin
                            s_d.nack = sda_lvl;
                        end
                        if (s_q.byten || sda_lvl) begin
                            s_d.st = ST_STOP;
                        end else begin
                            s_d.byten = 1'b1;
                            s_d.bitn  = 4'h0;
                            s_d.sh    = s_q.rw ? 8'hFF : s_q.wdat;
                        end
                    end
                end
            end
            ST_STOP: begin
                s_d.tmr = s_q.tmr + 8'h01;
                if (s_q.tmr == {1'b0, half[7:1]}) begin
                    s_d.sda_oe = 1'b1;
                end
                if (s_q.tmr == half) begin
                    s_d.scl_oe = 1'b0;
                end
                // a slave stretching the clock delays the stop
                if (s_q.tmr > half && !scl_lvl) begin
                    s_d.tmr = half + 8'h01;
                end
                if (s_q.tmr == 8'(half + half)) begin
                    s_d.sda_oe = 1'b0;
                end
                if (s_q.tmr == 8'(half + half + half)) begin
                    ev[ism_pkg::EV_DONE] = 1'b1;
                    ev[ism_pkg::EV_NACK] = s_q.nack;
                    s_d.st               = ST_IDLE;
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase

        // sticky events: a read clears only what it reported, so an
        // event landing between setup and access is not lost
        if (acc && !pwrite && paddr == ism_pkg::APB_STAT) begin
            s_d.stat = ev | (s_q.stat & ~s_q.prdata[1:0]);
        end else begin
            s_d.stat = s_q.stat | ev;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q    <= '0;
            s_q.st <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.host_scl_oe = s_q.scl_oe;
    assign link.host_sda_oe = s_q.sda_oe;
    assign prdata           = s_q.prdata;
    assign pready           = 1'b1;
    assign pslverr          = acc & ~mapped;
    assign irq              = |(s_q.stat & s_q.mask);
endmodule

//--- bench/ism_link_checker.sv
// link assertions for the slave handler on the open-drain bus
`timescale 1ns/1ps
module ism_link_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic dev_scl_oe,
    input wire logic dev_sda_oe,
    input wire logic host_scl_oe,
    input wire logic host_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    localparam int HOLD = int'(ism_pkg::LOW_HOLD_CYC);
    logic [7:0] hold_q;
    logic [4:0] rise_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // held-low length, and scl rises counted from the last start
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_q <= 8'h00;
            rise_q <= 5'h00;
        end else begin
            hold_q <= dev_scl_oe ? hold_q + {7'h00, ~&hold_q} : 8'h00;
            if (scl && $fell(sda)) rise_q <= 5'h00;
            else if ($rose(scl)) rise_q <= rise_q + 5'h01;
        end
    end
    sequence start_s;
        scl && $fell(sda);
    endsequence
    sequence quiet_s;
        !dev_sda_oe [*8];
    endsequence
    idle_release_a: assert property ($rose(reset_n) |-> !dev_scl_oe)
        else $error("clock line held after reset");
    hold_min_a: assert property ($fell(dev_scl_oe) |-> hold_q >= HOLD)
        else $error("clock released before low hold time");
    hold_start_a: assert property ($rose(dev_scl_oe) |-> !$past(scl, 2))
        else $error("clock hold not started in a low phase");
    word_end_a: assert property ($rose(dev_scl_oe) |->
        rise_q == 5'h09 || rise_q == 5'h12)
        else $error("clock hold not at a word end");
    ack_slot_a: assert property ($rose(dev_sda_oe) |-> rise_q >= 5'h08)
        else $error("data driven before address complete");
    start_quiet_a: assert property (start_s |-> quiet_s)
        else $error("data driven right after start");
    sda_stable_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("data changed while clock high");
    sda_pulse_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
        else $error("data drive too short");
endmodule

//--- bench/testbench.sv
// bench joining the slave handler and the far master over the link
`timescale 1ns/1ps
module testbench;
    logic        clk, reset_n, reg_wr, reg_rd, ev, psel, penable;
    logic        pwrite, pready, pslverr, irq, err_seen;
    logic [1:0]  reg_sel;
    logic [7:0]  reg_wdata, reg_rdata, paddr;
    logic [31:0] pwdata, prdata, rd;
    int          err_count, cmp_count, cyc, ev_cnt, n0;
    ism_link_if link ();
    ism_slave i_ism_slave (.clk(clk), .reset_n(reset_n), .link(link.dev),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bus_event_irq(ev));
    ism_master i_ism_master (.clk(clk), .reset_n(reset_n), .link(link.host),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    ism_link_checker i_ism_link_checker (.clk(clk), .reset_n(reset_n),
        .dev_scl_oe(link.dev_scl_oe), .dev_sda_oe(link.dev_sda_oe),
        .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
        .scl(link.scl), .sda(link.sda));
    always #20 clk = ~clk;
    // event tally and run ceiling
    always @(posedge clk) begin
        cyc++;
        if (ev === 1'b1) ev_cnt++;
        if (cyc == 60000) begin
            err_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // apb transfer; request held until pready seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // one-cycle strobe; read data lands one edge later
    task automatic dreg(input logic w, input logic [1:0] s,
                        input logic [7:0] d);
        reg_sel <= s;
        reg_wr <= w;
        reg_rd <= ~w;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clk);
        rd = {24'h0, reg_rdata};
    endtask
    // bounded wait for the event pulse or the master irq
    task automatic wait_on(input logic sel);
        int n;
        n = 0;
        while ((sel ? irq : ev) !== 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 5000) chk(32'h0, 32'h1);
        @(posedge clk);
    endtask
    task automatic fin(input logic [31:0] e);
        wait_on(1'b1);
        apb(1'b0, ism_pkg::APB_STAT, 32'h0);
        chk(rd, e);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask
    // event seen: clock held, release flag low, status as expected
    task automatic on_event(input logic [7:0] st);
        wait_on(1'b0);
        chk({31'h0, link.scl}, 32'h0);
        dreg(1'b0, ism_pkg::REG_CTRL, 8'h00);
        chk(rd, {24'h0, 1'b0, st[6], 6'h00});
        dreg(1'b0, ism_pkg::REG_STAT, 8'h00);
        chk(rd, {24'h0, st});
    endtask
    task automatic xfer_wr(input logic [7:0] a, input logic [7:0] d,
                           input logic [7:0] st);
        apb(1'b1, ism_pkg::APB_CMD, {15'h0000, 1'b1, d, a});
        on_event(st);
        if (st[1]) dreg(1'b1, ism_pkg::REG_CTRL, 8'h10);
        else dreg(1'b0, ism_pkg::REG_DATA, 8'h00);
        on_event(st[1] ? st : 8'h00);
        dreg(1'b0, ism_pkg::REG_DATA, 8'h00);
        chk(rd, {24'h0, d});
        fin(32'h1);
    endtask
    task automatic xfer_rd(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, ism_pkg::APB_CMD, {15'h0000, 1'b1, 8'h00, a});
        on_event(8'h44);
        dreg(1'b1, ism_pkg::REG_DATA, d);
        on_event(8'h41);
        dreg(1'b1, ism_pkg::REG_CTRL, 8'h50);
        dreg(1'b1, ism_pkg::REG_CTRL, 8'h10);
        fin(32'h1);
        apb(1'b0, ism_pkg::APB_RXD, 32'h0);
        chk(rd, {24'h0, d});
    endtask
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {reg_wr, reg_rd, psel, penable, pwrite} = 5'h00;
        reg_sel = 2'h0;
        reg_wdata = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        dreg(1'b0, ism_pkg::REG_CTRL, 8'h00);
        chk(rd, 32'h10);
        dreg(1'b1, ism_pkg::REG_ADDR, 8'hA4);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err_seen}, 32'h1);
        apb(1'b1, ism_pkg::APB_MASK, 32'h1);
        n0 = ev_cnt;
        apb(1'b1, ism_pkg::APB_CMD, 32'h0001_0050);
        wait_on(1'b1);
        chk(32'(ev_cnt - n0), 32'h0);
        apb(1'b1, ism_pkg::APB_MASK, 32'h0);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ism_pkg::APB_MASK, 32'h1);
        fin(32'h3);
        xfer_wr(8'hA4, 8'h3C, 8'h04);
        xfer_wr(8'h00, 8'h5A, 8'h06);
        xfer_rd(8'hA5, 8'h96);
        dreg(1'b1, ism_pkg::REG_ADDR, 8'h00);
        xfer_rd(8'h01, 8'hC3);
        // lost in address, own address missed: event, no hold
        dreg(1'b1, ism_pkg::REG_CTRL, 8'hC0);
        dreg(1'b1, ism_pkg::REG_DATA, 8'hFE);
        apb(1'b1, ism_pkg::APB_CMD, 32'h0001_0050);
        wait_on(1'b0);
        chk({31'h0, link.dev_scl_oe}, 32'h0);
        dreg(1'b0, ism_pkg::REG_CTRL, 8'h00);
        chk(rd, 32'h10);
        dreg(1'b0, ism_pkg::REG_STAT, 8'h00);
        chk(rd, 32'h09);
        dreg(1'b0, ism_pkg::REG_DATA, 8'h00);
        dreg(1'b0, ism_pkg::REG_STAT, 8'h00);
        chk(rd, 32'h01);
        fin(32'h3);
        print_verdict();
    end
endmodule
